/* File: logic/card_session.v */
// card session logic: reset detection, answer to reset, speed negotiation,
// security status and clock stop tracking, with an apb register slave.
// assumes a character framing layer on clk that moves bytes over tx/rx and
// uses fidi and low_imp for its bit timing; pins arrive unsynchronised.
// Operation
// (RULE1) global tb byte only 00 or 90
// (RULE2) tb bits b8 and b5 flag low impedance
// (RULE3) no reserved tb encodings ever emitted
// (RULE4) negotiation only way off default speed
// (RULE5) every negotiation request gets a response
// (RULE6) accept and confirm pps2 equal 00
// (RULE7) accept and confirm pps2 90 if offered
// (RULE8) answer parameters coded per base standard
// (RULE9) cold reset: negotiable, no ta2 byte
// (RULE10) cold reset clears security status
// (RULE11) denied access returns status 69 82
// (RULE12) warm reset enters one fixed mode
// (RULE13) specific type sends ta2 after warm
// (RULE14) specific mode keeps negotiated speed in ta1
// (RULE15) warm resets give identical answers
// (RULE16) warm reset clears security status
// (RULE17) clock stop offered, ta3 b8 b7 set
// (RULE18) state kept while clock halted
// (RULE19) command after 744 restart cycles served
// (RULE20) bit timing left to framing layer
// (RULE21) supports 372/1, 512/8, 512/16 speeds
// (RULE22) answer carries t=15 global bytes
// (RULE23) warm mode fixed, speed kept till cold
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`include "card_session_regs.vh"

module card_session
#(
   parameter WARM_SPECIFIC = 1'b0
)
(
   input wire clk,
   input wire reset_n,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire card_vcc_pin,
   input wire card_rst_pin,
   input wire card_clk_pin,
   input wire rx_valid,
   input wire [7:0] rx_data,
   output wire tx_valid,
   output wire [7:0] tx_data,
   input wire tx_ready,
   output wire cmd_valid,
   output wire [7:0] cmd_data,
   output wire [7:0] fidi,
   output wire low_imp,
   output wire specific_mode,
   output wire clock_stopped
);

localparam [2:0] ST_IDLE = 3'd0;
localparam [2:0] ST_ATR = 3'd1;
localparam [2:0] ST_WAIT_PPS = 3'd2;
localparam [2:0] ST_PPS_RX = 3'd3;
localparam [2:0] ST_PPS_TX = 3'd4;
localparam [2:0] ST_SESSION = 3'd5;

localparam integer STOP_CYC_I = (`STOP_NS + `CLK_NS - 1) / `CLK_NS;
localparam [7:0] STOP_CYC = STOP_CYC_I[7:0];

// ----------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------
wire vcc_s;
wire rst_s;
wire cclk_s;

pin_sync3 u_sync_vcc
(
   .clk(clk),
   .reset_n(reset_n),
   .pin_in(card_vcc_pin),
   .level(vcc_s)
);

pin_sync3 u_sync_rst
(
   .clk(clk),
   .reset_n(reset_n),
   .pin_in(card_rst_pin),
   .level(rst_s)
);

pin_sync3 u_sync_clk
(
   .clk(clk),
   .reset_n(reset_n),
   .pin_in(card_clk_pin),
   .level(cclk_s)
);

// ----------------------------------------------------------------------
// state
// ----------------------------------------------------------------------
reg [2:0] state_ff;
reg rst_prev_ff;
reg warm_ok_ff;
reg cold_flag_ff;
reg [1:0] ctrl_ff;
reg tb_adv_ff;
reg tb_lowimp_ff;
reg specific_ff;
reg [7:0] fidi_ff;
reg [7:0] neg_fidi_ff;
reg low_imp_ff;
reg sec_ok_ff;
reg [3:0] slot_ff;
reg [7:0] chk_ff;
reg tx_valid_ff;
reg [7:0] tx_data_ff;
reg [7:0] pps0_ff;
reg [7:0] pps1_ff;
reg [7:0] pps2_ff;
reg [2:0] rem_ff;
reg [7:0] rsp0_ff;
reg cmd_valid_ff;
reg [7:0] cmd_data_ff;
reg cclk_prev_ff;
reg [7:0] idle_cnt_ff;
reg stopped_ff;
reg [9:0] wake_cnt_ff;
reg [31:0] prdata_ff;

wire rst_rise = rst_s & ~rst_prev_ff;
wire is_cold = ~warm_ok_ff;
wire in_tx = (state_ff == ST_ATR) || (state_ff == ST_PPS_TX);
wire last_slot = (state_ff == ST_ATR) ? (slot_ff == `SLOT_TCK) : (slot_ff == `PSLOT_PCK);

// ----------------------------------------------------------------------
// outgoing byte for the current slot
// ----------------------------------------------------------------------
reg [7:0] cur_byte;
reg slot_ok;

always @*
begin
   cur_byte = 8'h00;
   slot_ok = 1'b1;
   if (state_ff == ST_PPS_TX)
   begin
      case (slot_ff)
         `PSLOT_PPSS: cur_byte = `PPSS_BYTE;
         `PSLOT_PPS0: cur_byte = rsp0_ff;
         `PSLOT_PPS1:
         begin
            cur_byte = pps1_ff;
            slot_ok = rsp0_ff[4];
         end
         `PSLOT_PPS2:
         begin
            cur_byte = pps2_ff;
            slot_ok = rsp0_ff[5];
         end
         default: cur_byte = chk_ff;
      endcase
   end
   else
   begin
      case (slot_ff)
         `SLOT_TS: cur_byte = `ATR_TS;
         `SLOT_T0: cur_byte = `ATR_T0;
         `SLOT_TA1: cur_byte = specific_ff ? neg_fidi_ff : `ATR_TA1_MAX; // RULE14
         `SLOT_TD1: cur_byte = specific_ff ? `ATR_TD1_SPEC : `ATR_TD1_NEG; // RULE8
         `SLOT_TA2:
         begin
            cur_byte = `ATR_TA2;
            slot_ok = specific_ff; // RULE9 RULE13
         end
         `SLOT_TD2: cur_byte = tb_adv_ff ? `ATR_TD2_TB : `ATR_TD2_NOTB; // RULE22
         `SLOT_TA3: cur_byte = `ATR_TA3; // RULE17
         `SLOT_TB3:
         begin
            cur_byte = tb_lowimp_ff ? `ATR_TB3_LOWIMP : `ATR_TB3_NONE; // RULE1 RULE2 RULE3
            slot_ok = tb_adv_ff;
         end
         `SLOT_H0: cur_byte = `ATR_HIST0;
         `SLOT_H1: cur_byte = `ATR_HIST1;
         `SLOT_H2: cur_byte = `ATR_HIST2;
         `SLOT_H3: cur_byte = `ATR_HIST3;
         `SLOT_H4: cur_byte = `ATR_HIST4;
         `SLOT_H5: cur_byte = `ATR_HIST5;
         default: cur_byte = chk_ff;
      endcase
   end
end

// ----------------------------------------------------------------------
// negotiation request check, evaluated on the closing check byte
// ----------------------------------------------------------------------
wire [7:0] pps_xor = chk_ff ^ rx_data;
wire pps_good = (pps_xor == 8'h00) && (pps0_ff[3:0] == 4'h0);
wire fidi_good = (pps1_ff == `FIDI_DEFAULT) || (pps1_ff == `FIDI_512_8) ||
   (pps1_ff == `FIDI_512_16); // RULE21
wire pps2_good = (pps2_ff == `PPS2_NONE) ||
   ((pps2_ff == `PPS2_LOWIMP) && tb_adv_ff && tb_lowimp_ff); // RULE6 RULE7
wire [7:0] rsp0_nxt = {2'b00, pps_good & pps0_ff[5] & pps2_good,
   pps_good & pps0_ff[4] & fidi_good, 4'h0};

// ----------------------------------------------------------------------
// session state machine
// ----------------------------------------------------------------------
always @(posedge clk)
begin
   if (!reset_n)
   begin
      state_ff <= ST_IDLE;
      rst_prev_ff <= 1'b0;
      warm_ok_ff <= 1'b0;
      cold_flag_ff <= 1'b0;
      tb_adv_ff <= 1'b0;
      tb_lowimp_ff <= 1'b0;
      specific_ff <= 1'b0;
      fidi_ff <= `FIDI_DEFAULT;
      neg_fidi_ff <= `FIDI_DEFAULT;
      low_imp_ff <= 1'b0;
      slot_ff <= 4'd0;
      chk_ff <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      pps0_ff <= 8'h00;
      pps1_ff <= `FIDI_DEFAULT;
      pps2_ff <= `PPS2_NONE;
      rem_ff <= 3'd0;
      rsp0_ff <= 8'h00;
      cmd_valid_ff <= 1'b0;
      cmd_data_ff <= 8'h00;
   end
   else
   begin
      rst_prev_ff <= rst_s;
      cmd_valid_ff <= 1'b0;
      if (!vcc_s)
         warm_ok_ff <= 1'b0;
      if (!rst_s)
      begin
         state_ff <= ST_IDLE;
         tx_valid_ff <= 1'b0;
      end
      else if (rst_rise && vcc_s)
      begin
         warm_ok_ff <= 1'b1;
         cold_flag_ff <= is_cold;
         state_ff <= ST_ATR;
         slot_ff <= `SLOT_TS;
         chk_ff <= 8'h00;
         low_imp_ff <= 1'b0;
         if (is_cold)
         begin
            tb_adv_ff <= ctrl_ff[`CTRL_TB_ADV];
            tb_lowimp_ff <= ctrl_ff[`CTRL_TB_LOWIMP];
            specific_ff <= 1'b0; // RULE9
            fidi_ff <= `FIDI_DEFAULT;
            neg_fidi_ff <= `FIDI_DEFAULT; // RULE23
         end
         else
         begin
            specific_ff <= WARM_SPECIFIC; // RULE12 RULE23
            fidi_ff <= WARM_SPECIFIC ? neg_fidi_ff : `FIDI_DEFAULT; // RULE14 RULE15
         end
      end
      else
      begin
         case (state_ff)
            ST_ATR, ST_PPS_TX:
            begin
               if (!tx_valid_ff)
               begin
                  if (slot_ok)
                  begin
                     tx_data_ff <= cur_byte;
                     tx_valid_ff <= 1'b1;
                  end
                  else
                     slot_ff <= slot_ff + 4'd1;
               end
               else if (tx_ready)
               begin
                  tx_valid_ff <= 1'b0;
                  slot_ff <= slot_ff + 4'd1;
                  if ((slot_ff != 4'd0) || (state_ff == ST_PPS_TX))
                     chk_ff <= chk_ff ^ tx_data_ff;
                  if (last_slot && (state_ff == ST_ATR))
                     state_ff <= specific_ff ? ST_SESSION : ST_WAIT_PPS; // RULE4
                  else if (last_slot)
                  begin
                     state_ff <= ST_SESSION;
                     if (rsp0_ff[4])
                     begin
                        fidi_ff <= pps1_ff; // RULE4
                        neg_fidi_ff <= pps1_ff;
                     end
                     if (rsp0_ff[5])
                        low_imp_ff <= pps2_ff[7] & pps2_ff[4];
                  end
               end
            end
            ST_WAIT_PPS:
            begin
               if (rx_valid && (rx_data == `PPSS_BYTE))
               begin
                  state_ff <= ST_PPS_RX;
                  chk_ff <= rx_data;
                  rem_ff <= 3'd0;
                  pps0_ff <= 8'h00;
                  pps1_ff <= `FIDI_DEFAULT;
                  pps2_ff <= `PPS2_NONE;
                  slot_ff <= 4'd0;
               end
               else if (rx_valid)
               begin
                  state_ff <= ST_SESSION;
                  cmd_valid_ff <= 1'b1;
                  cmd_data_ff <= rx_data;
               end
            end
            ST_PPS_RX:
            begin
               if (rx_valid)
               begin
                  chk_ff <= pps_xor;
                  if (slot_ff == 4'd0)
                  begin
                     pps0_ff <= rx_data;
                     rem_ff <= rx_data[6:4];
                     slot_ff <= 4'd1;
                  end
                  else if (rem_ff[0])
                  begin
                     pps1_ff <= rx_data;
                     rem_ff[0] <= 1'b0;
                  end
                  else if (rem_ff[1])
                  begin
                     pps2_ff <= rx_data;
                     rem_ff[1] <= 1'b0;
                  end
                  else if (rem_ff[2])
                     rem_ff[2] <= 1'b0;
                  else
                  begin
                     rsp0_ff <= rsp0_nxt; // RULE5
                     state_ff <= ST_PPS_TX;
                     slot_ff <= `PSLOT_PPSS;
                     chk_ff <= 8'h00;
                  end
               end
            end
            ST_SESSION:
            begin
               if (rx_valid)
               begin
                  cmd_valid_ff <= 1'b1; // RULE18 RULE19
                  cmd_data_ff <= rx_data;
               end
            end
            default:
               tx_valid_ff <= 1'b0;
         endcase
      end
   end
end

// ----------------------------------------------------------------------
// clock stop tracking: state is never touched by a halted clock
// ----------------------------------------------------------------------
always @(posedge clk)
begin
   if (!reset_n)
   begin
      cclk_prev_ff <= 1'b0;
      idle_cnt_ff <= 8'd0;
      stopped_ff <= 1'b0;
      wake_cnt_ff <= `RESTART_EDGES;
   end
   else
   begin
      cclk_prev_ff <= cclk_s;
      if (cclk_s != cclk_prev_ff)
      begin
         idle_cnt_ff <= 8'd0;
         if (stopped_ff)
         begin
            stopped_ff <= 1'b0;
            wake_cnt_ff <= 10'd0;
         end
         else if (cclk_s && (wake_cnt_ff != `RESTART_EDGES))
            wake_cnt_ff <= wake_cnt_ff + 10'd1; // RULE19
      end
      else if (idle_cnt_ff != STOP_CYC)
         idle_cnt_ff <= idle_cnt_ff + 8'd1;
      else if (state_ff != ST_IDLE && state_ff != ST_ATR)
         stopped_ff <= 1'b1; // RULE18
   end
end

// ----------------------------------------------------------------------
// apb slave
// ----------------------------------------------------------------------
wire setup = psel & ~penable;
wire access = psel & penable;
wire wr = access & pwrite;
reg mapped;

always @*
begin
   if (paddr == `ADDR_CTRL)
      mapped = 1'b1;
   else if (paddr == `ADDR_STATUS)
      mapped = 1'b1;
   else if (paddr == `ADDR_SEC)
      mapped = 1'b1;
   else if (paddr == `ADDR_ACCESS)
      mapped = 1'b1;
   else
      mapped = 1'b0;
end

always @(posedge clk)
begin
   if (!reset_n)
   begin
      ctrl_ff <= `CTRL_RESET;
      sec_ok_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
   end
   else
   begin
      if (rst_rise)
         sec_ok_ff <= 1'b0; // RULE10 RULE16
      else if (wr && (paddr == `ADDR_SEC) && pwdata[`SEC_SET])
         sec_ok_ff <= 1'b1;
      else if (wr && (paddr == `ADDR_SEC) && pwdata[`SEC_CLR])
         sec_ok_ff <= 1'b0;
      if (wr && (paddr == `ADDR_CTRL))
         ctrl_ff <= pwdata[1:0];
      if (setup)
      begin
         if (paddr == `ADDR_CTRL)
            prdata_ff <= {30'h0, ctrl_ff};
         else if (paddr == `ADDR_STATUS)
            prdata_ff <= {15'h0, wake_cnt_ff == `RESTART_EDGES, fidi_ff, sec_ok_ff,
               stopped_ff, low_imp_ff, specific_ff, cold_flag_ff, state_ff};
         else if (paddr == `ADDR_SEC)
            prdata_ff <= {31'h0, sec_ok_ff};
         else if (paddr == `ADDR_ACCESS)
            prdata_ff <= {16'h0, sec_ok_ff ? `SW_OK : `SW_DENY}; // RULE11
         else
            prdata_ff <= 32'h00000000;
      end
   end
end

assign prdata = prdata_ff;
assign pready = 1'b1;
assign pslverr = access & ~mapped;
assign tx_valid = tx_valid_ff & in_tx;
assign tx_data = tx_data_ff;
assign cmd_valid = cmd_valid_ff;
assign cmd_data = cmd_data_ff;
assign fidi = fidi_ff; // RULE20
assign low_imp = low_imp_ff;
assign specific_mode = specific_ff;
assign clock_stopped = stopped_ff;

endmodule

/* File: logic/pin_sync3.v */
// three-stage synchroniser for one pin input.
// assumes a slow level from outside the clk domain; output moves only when
// the second and third stages agree.
`timescale 1ns/100ps

module pin_sync3
(
   input wire clk,
   input wire reset_n,
   input wire pin_in,
   output wire level
);

reg s1_ff;
reg s2_ff;
reg s3_ff;
reg level_ff;

always @(posedge clk)
begin
   if (!reset_n)
   begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
   end
   else
   begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
      begin
         level_ff <= s3_ff;
      end
   end
end

assign level = level_ff;

endmodule

/* File: shared/card_session_regs.vh */
// constants for the card session block: register map, answer-to-reset bytes,
// negotiation codes, status words and timing. definitions only.
`ifndef CARD_SESSION_REGS_VH
`define CARD_SESSION_REGS_VH

// ----------------------------------------------------------------------
// apb register byte addresses
// ----------------------------------------------------------------------
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_SEC 12'h008
`define ADDR_ACCESS 12'h00C

// ----------------------------------------------------------------------
// register fields
// ----------------------------------------------------------------------
`define CTRL_TB_ADV 0
`define CTRL_TB_LOWIMP 1
`define SEC_SET 0
`define SEC_CLR 1
`define CTRL_RESET 2'h1

// ----------------------------------------------------------------------
// answer-to-reset bytes
// ----------------------------------------------------------------------
`define ATR_TS 8'h3B
`define ATR_T0 8'h96
`define ATR_TA1_MAX 8'h95
`define ATR_TD1_NEG 8'h80
`define ATR_TD1_SPEC 8'h90
`define ATR_TA2 8'h80
`define ATR_TD2_TB 8'h3F
`define ATR_TD2_NOTB 8'h1F
`define ATR_TA3 8'hC3
`define ATR_TB3_NONE 8'h00
`define ATR_TB3_LOWIMP 8'h90
`define ATR_HIST0 8'h80
`define ATR_HIST1 8'h31
`define ATR_HIST2 8'hA0
`define ATR_HIST3 8'h73
`define ATR_HIST4 8'hBE
`define ATR_HIST5 8'h21

// ----------------------------------------------------------------------
// answer slots: ta2 and tb3 are optional, tck closes the answer
// ----------------------------------------------------------------------
`define SLOT_TS 4'd0
`define SLOT_T0 4'd1
`define SLOT_TA1 4'd2
`define SLOT_TD1 4'd3
`define SLOT_TA2 4'd4
`define SLOT_TD2 4'd5
`define SLOT_TA3 4'd6
`define SLOT_TB3 4'd7
`define SLOT_H0 4'd8
`define SLOT_H1 4'd9
`define SLOT_H2 4'd10
`define SLOT_H3 4'd11
`define SLOT_H4 4'd12
`define SLOT_H5 4'd13
`define SLOT_TCK 4'd14
`define PSLOT_PPSS 4'd0
`define PSLOT_PPS0 4'd1
`define PSLOT_PPS1 4'd2
`define PSLOT_PPS2 4'd3
`define PSLOT_PCK 4'd4

// ----------------------------------------------------------------------
// negotiation codes and status words
// ----------------------------------------------------------------------
`define FIDI_DEFAULT 8'h11
`define FIDI_512_8 8'h94
`define FIDI_512_16 8'h95
`define PPSS_BYTE 8'hFF
`define PPS2_NONE 8'h00
`define PPS2_LOWIMP 8'h90
`define SW_DENY 16'h6982
`define SW_OK 16'h9000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_NS 50
`define STOP_NS 10000
`define RESTART_EDGES 10'd744

`endif

/* File: testbench/card_session_asserts.sv */
// checker for the card session block, bound to every instance.
// assumes one byte moves on each edge with tx_valid and tx_ready high.
`timescale 1ns/100ps
`include "card_session_regs.vh"

module card_session_asserts
(
   input wire clk,
   input wire reset_n,
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] prdata,
   input wire card_rst_pin,
   input wire rx_valid,
   input wire [7:0] rx_data,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire tx_ready,
   input wire cmd_valid,
   input wire [7:0] cmd_data,
   input wire [7:0] fidi,
   input wire low_imp,
   input wire specific_mode,
   input wire clock_stopped
);
   wire acc = tx_valid && tx_ready;
   reg [3:0] cnt_ff;
   reg [7:0] prev_ff;
   reg [7:0] prev2_ff;

   // ----------------------------------------
   // byte position within the answer
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (!reset_n || !card_rst_pin)
      begin
         cnt_ff <= 4'h0;
         prev_ff <= 8'h00;
         prev2_ff <= 8'h00;
      end
      else if (acc)
      begin
         if (cnt_ff != 4'hF)
            cnt_ff <= cnt_ff + 4'h1;
         prev_ff <= tx_data;
         prev2_ff <= prev_ff;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_tb_val;
      acc && prev2_ff == `ATR_TD2_TB && prev_ff == `ATR_TA3
         |-> tx_data == 8'h00 || tx_data == 8'h90;
   endproperty
   a_tb_val: assert property (p_tb_val)
      else $error("global tb byte out of range");
   property p_lowimp;
      $rose(low_imp) |-> $past(acc);
   endproperty
   a_lowimp: assert property (p_lowimp)
      else $error("low impedance set outside a response byte");
   property p_fidi_chg;
      $changed(fidi) && fidi != `FIDI_DEFAULT |-> $past(acc);
   endproperty
   a_fidi_chg: assert property (p_fidi_chg)
      else $error("speed left default without negotiation");
   property p_fidi_set;
      fidi == 8'h11 || fidi == 8'h94 || fidi == 8'h95;
   endproperty
   a_fidi_set: assert property (p_fidi_set)
      else $error("unsupported speed code");
   property p_td1;
      acc && cnt_ff == 4'h3 |-> tx_data[4] == specific_mode;
   endproperty
   a_td1: assert property (p_td1)
      else $error("ta2 presence does not match mode");
   property p_td2;
      acc && cnt_ff == (specific_mode ? 4'h5 : 4'h4) |-> tx_data[3:0] == 4'hF;
   endproperty
   a_td2: assert property (p_td2)
      else $error("second td byte lacks t15");
   property p_ta3;
      acc && cnt_ff < 4'h8 && (prev_ff == `ATR_TD2_TB || prev_ff == `ATR_TD2_NOTB)
         |-> tx_data[7:6] != 2'b00;
   endproperty
   a_ta3: assert property (p_ta3)
      else $error("clock stop not offered");
   property p_cmd;
      cmd_valid |-> $past(rx_valid) && cmd_data == $past(rx_data);
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("command byte not forwarded as received");
   property p_access;
      psel && penable && !pwrite && paddr == `ADDR_ACCESS
         |-> prdata == 32'h00006982 || prdata == 32'h00009000;
   endproperty
   a_access: assert property (p_access)
      else $error("bad status word");

   c_lowimp: cover property ($rose(low_imp));
   c_stop: cover property ($rose(clock_stopped));
   c_ta2: cover property (acc && cnt_ff == 4'h4 && specific_mode);
endmodule

bind card_session card_session_asserts i_asserts
(
   .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .card_rst_pin(card_rst_pin), .rx_valid(rx_valid),
   .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
   .cmd_valid(cmd_valid), .cmd_data(cmd_data), .fidi(fidi), .low_imp(low_imp),
   .specific_mode(specific_mode), .clock_stopped(clock_stopped)
);

/* File: testbench/card_terminal.sv */
// terminal model: card supply, reset and clock pins, byte side of framing.
// assumes the bench calls its tasks and drains the got queue.
`timescale 1ns/100ps

module card_terminal
(
   input wire clk,
   output reg vcc_pin,
   output reg rst_pin,
   output reg clk_pin,
   output reg rx_valid,
   output reg [7:0] rx_data,
   input wire tx_valid,
   input wire [7:0] tx_data,
   output reg tx_ready
);
   reg run = 1'b1;
   reg slow = 1'b1;
   reg [1:0] k = 2'h0;
   reg [7:0] got [$];

   initial
   begin
      vcc_pin = 1'b0;
      rst_pin = 1'b0;
      clk_pin = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end

   always @(posedge clk)
   begin
      k <= k + 2'h1;
      if (run && k[0])
         clk_pin <= ~clk_pin;
      tx_ready <= !slow || k == 2'h3;
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
   end

   task cold;
      @(posedge clk);
      rst_pin <= 1'b0;
      vcc_pin <= 1'b0;
      repeat (8) @(posedge clk);
      vcc_pin <= 1'b1;
      repeat (8) @(posedge clk);
      rst_pin <= 1'b1;
   endtask

   task warm;
      @(posedge clk);
      rst_pin <= 1'b0;
      repeat (8) @(posedge clk);
      rst_pin <= 1'b1;
   endtask

   task send(input [7:0] b);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      // released line must not echo the byte
      rx_data <= ~b;
      repeat (3) @(posedge clk);
   endtask
endmodule

/* File: testbench/tb_card_session.sv */
// testbench: apb register tasks, card resets, negotiation and clock stop.
// assumes the terminal model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`include "card_session_regs.vh"

module tb_card_session;
   localparam SPEC = 1'b1;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [31:0] pwdata = 32'h00000000;
   wire [31:0] prdata;
   wire pready, pslverr, vcc, rst, cclk, rxv, txv, txr, cmdv, limp, spec, stop;
   wire [7:0] rxd, txd, cmdd, fidi;
   reg [31:0] rd;
   reg err;
   reg [7:0] e [$];
   reg [7:0] last_cmd = 8'h00;
   integer n_fail = 0;
   integer checked = 0;

   always #25 clk = ~clk;

   card_session #(.WARM_SPECIFIC(SPEC)) i_dut
   (
      .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .card_vcc_pin(vcc), .card_rst_pin(rst), .card_clk_pin(cclk),
      .rx_valid(rxv), .rx_data(rxd), .tx_valid(txv), .tx_data(txd), .tx_ready(txr),
      .cmd_valid(cmdv), .cmd_data(cmdd), .fidi(fidi), .low_imp(limp),
      .specific_mode(spec), .clock_stopped(stop)
   );

   card_terminal i_term
   (
      .clk(clk), .vcc_pin(vcc), .rst_pin(rst), .clk_pin(cclk), .rx_valid(rxv),
      .rx_data(rxd), .tx_valid(txv), .tx_data(txd), .tx_ready(txr)
   );

   always @(posedge clk)
      if (cmdv === 1'b1)
         last_cmd <= cmdd;

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task complete_run;
      if (n_fail == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task cmp(input [31:0] got, input [31:0] exp);
      checked = checked + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task apb(input w, input [11:0] a, input [31:0] d);
      integer t;
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && t < 50)
      begin
         @(posedge clk);
         t = t + 1;
      end
      if (t >= 50)
         n_fail = n_fail + 1;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task rchk(input [11:0] a, input [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      cmp(rd, exp);
   endtask

   task exp_atr(input sp, input [7:0] ta1, input [7:0] tb);
      integer i;
      reg [7:0] x;
      e = {`ATR_TS, `ATR_T0, ta1};
      e.push_back(sp ? `ATR_TD1_SPEC : `ATR_TD1_NEG);
      if (sp)
         e.push_back(`ATR_TA2);
      e = {e, `ATR_TD2_TB, `ATR_TA3, tb, `ATR_HIST0, `ATR_HIST1, `ATR_HIST2};
      e = {e, `ATR_HIST3, `ATR_HIST4, `ATR_HIST5};
      x = 8'h00;
      for (i = 1; i < e.size(); i = i + 1)
         x = x ^ e[i];
      e.push_back(x);
   endtask

   task chk_tx;
      integer t, i;
      t = 0;
      while (i_term.got.size() < e.size() && t < 2000)
      begin
         @(posedge clk);
         t = t + 1;
      end
      @(posedge clk);
      cmp(i_term.got.size(), e.size());
      for (i = 0; i < e.size() && i < i_term.got.size(); i = i + 1)
         cmp(i_term.got[i], e[i]);
      i_term.got.delete();
   endtask

   task pps;
      integer i;
      for (i = 0; i < e.size(); i = i + 1)
         i_term.send(e[i]);
      chk_tx;
   endtask

   initial
   begin
      repeat (40000) @(posedge clk);
      n_fail = n_fail + 1;
      complete_run;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rchk(`ADDR_CTRL, 32'h00000001);
      rchk(`ADDR_ACCESS, 32'h00006982);
      rchk(12'h010, 32'h00000000);
      cmp(err, 1'b1);
      i_term.cold();
      exp_atr(1'b0, `ATR_TA1_MAX, 8'h00);
      chk_tx;
      i_term.slow <= 1'b0;
      e = {8'hFF, 8'h30, 8'h94, 8'h00, 8'h5B};
      pps;
      cmp(fidi, 8'h94);
      apb(1'b1, `ADDR_SEC, 32'h00000001);
      rchk(`ADDR_ACCESS, 32'h00009000);
      repeat (20) @(posedge clk);
      i_term.run <= 1'b0;
      repeat (300) @(posedge clk);
      cmp(stop, 1'b1);
      cmp(fidi, 8'h94);
      i_term.run <= 1'b1;
      repeat (3100) @(posedge clk);
      apb(1'b0, `ADDR_STATUS, 32'h00000000);
      cmp(rd[16], 1'b1);
      cmp(stop, 1'b0);
      i_term.send(8'hA4);
      cmp(last_cmd, 8'hA4);
      i_term.warm();
      exp_atr(SPEC, SPEC ? 8'h94 : `ATR_TA1_MAX, 8'h00);
      chk_tx;
      cmp(spec, SPEC);
      rchk(`ADDR_ACCESS, 32'h00006982);
      apb(1'b1, `ADDR_SEC, 32'h00000001);
      i_term.warm();
      chk_tx;
      rchk(`ADDR_ACCESS, 32'h00006982);
      apb(1'b1, `ADDR_CTRL, 32'h00000003);
      apb(1'b1, `ADDR_SEC, 32'h00000001);
      i_term.cold();
      exp_atr(1'b0, `ATR_TA1_MAX, 8'h90);
      chk_tx;
      rchk(`ADDR_ACCESS, 32'h00006982);
      cmp(fidi, 8'h11);
      e = {8'hFF, 8'h30, 8'h95, 8'h90, 8'hCA};
      pps;
      cmp(limp, 1'b1);
      cmp(fidi, 8'h95);
      i_term.send(8'h5A);
      cmp(last_cmd, 8'h5A);
      complete_run;
   end
endmodule
